// ### burst_sram_core.sv
// two-port burst sram: write and read ports, two-word bursts, lane masks
// assumes pin clocks are far slower than i_mclk so each pin edge is seen
// Behaviour
// [RL1] write starts on k rise with select low; second word and address on kn rise
// [RL2] read latches address on k rise; words on cn at t+1, c at t+2
// [RL3] both selects high: no access, write data ignored, read outputs high impedance
// [RL4] stopped input clock keeps inputs and outputs in their previous state
// [RL5] after power-up both ports idle and read outputs high impedance
// [RL6] first word uses address low bit zero, second word low bit one
// [RL7] write data on both input clock rises; read data on both output clocks
// [RL8] controller should park clocks with k equal kn and c high; park in the model leaves c untouched, low in dual clock mode
// [RL9] two-lane parts: each low lane select writes its half; others unchanged
// [RL10] all lane selects high in one half leaves that word untouched
// [RL11] 36-bit part: four low-active selects gate 9-bit lanes
// [RL12] lane select three gates bits 35 to 27
// [RL13] lane selects sampled separately on each half of a write burst
// [RL14] both c pins high from power-on select single clock mode, fixed
// [RL15] concurrent read and write to one location return newest data
// [RL16] deselecting one port leaves the other alone; pending accesses finish
// [RL17] after second read word outputs return to high impedance next edge
`timescale 1ns/1ps
`include "sram_map.svh"

module burst_sram_core
#(
   parameter sram_pkg::org_t ORG = sram_pkg::ORG_X36
)
(
   // clock and reset
   input  wire logic                   i_mclk,
   input  wire logic                   i_rst,
   // input and output clock pins
   input  wire logic                   i_k,
   input  wire logic                   i_k_n,
   input  wire logic                   i_c,
   input  wire logic                   i_c_n,
   // port selects and lane selects
   input  wire logic                   i_read_port_select_n,
   input  wire logic                   i_write_port_select_n,
   input  wire logic [`SRAM_LANES-1:0] i_lane_write_select_n,
   // address and write data
   input  wire logic [`SRAM_AW-1:0]    i_addr,
   input  wire logic [`SRAM_DW-1:0]    i_wdata,
   // read data pins and single clock mode flag
   output logic [`SRAM_DW-1:0]         o_rdata,
   output logic                        o_rdata_oe,
   output logic                        o_single_clock_mode
);

   // pin synchronisers
   logic [`CK_W-1:0]       ck_s1_reg;
   logic [`CK_W-1:0]       ck_s2_reg;
   logic [`CK_W-1:0]       ck_prev_reg;
   logic [`CTL_W-1:0]      ctl_s1_reg;
   logic [`CTL_W-1:0]      ctl_s2_reg;
   logic [`SRAM_AW-1:0]    addr_s1_reg;
   logic [`SRAM_AW-1:0]    addr_s2_reg;
   logic [`SRAM_DW-1:0]    data_s1_reg;
   logic [`SRAM_DW-1:0]    data_s2_reg;

   // strap capture
   logic [1:0]             strap_cnt_reg;
   logic                   strap_done_reg;
   logic                   single_reg;

   // memory halves: even holds word 0, odd holds word 1 of each burst
   logic [`SRAM_DW-1:0]    mem_even [2**`SRAM_AW];
   logic [`SRAM_DW-1:0]    mem_odd  [2**`SRAM_AW];

   // write port
   sram_pkg::wr_state_t    wr_state_reg;
   logic [`SRAM_DW-1:0]    w0_data_reg;
   logic [`SRAM_DW-1:0]    w0_mask_reg;

   // read port
   logic                   rd_pend_reg;
   logic [`SRAM_AW-1:0]    rd_addr_reg;
   logic [1:0]             src_cnt_reg;
   logic [`SRAM_DW-1:0]    src_w0_reg;
   logic [`SRAM_DW-1:0]    src_w1_reg;

   // combinational
   logic [`CK_W-1:0]       rise;
   logic                   k_rise;
   logic                   kn_rise;
   logic                   first_edge;
   logic                   second_edge;
   logic                   rd_sel_n;
   logic                   wr_sel_n;
   logic [`SRAM_LANES-1:0] lane_n;
   logic                   wr_commit;
   logic [`SRAM_DW-1:0]    w1_mask;
   logic [`SRAM_DW-1:0]    even_new;
   logic [`SRAM_DW-1:0]    odd_new;
   logic                   fetch;
   logic                   fwd_hit;
   logic [`SRAM_DW-1:0]    fetch_w0;
   logic [`SRAM_DW-1:0]    fetch_w1;
   logic                   buf_in_valid;
   logic                   buf_in_ready;
   logic [`BUF_W-1:0]      buf_in_data;
   logic                   buf_out_valid;
   logic                   buf_out_ready;
   logic [`BUF_W-1:0]      buf_out_data;
   logic                   pop;

   // write-enable mask for one burst half from its lane selects
   function automatic logic [`SRAM_DW-1:0] lane_mask(input logic [`SRAM_LANES-1:0] sel_n);
      logic [`SRAM_DW-1:0] m;
      m = '0;
      unique case (ORG)
         sram_pkg::ORG_X8:
         begin
            m[0 +: `SRAM_NIB_W]           = {`SRAM_NIB_W{~sel_n[0]}}; // [RL9]
            m[`SRAM_NIB_W +: `SRAM_NIB_W] = {`SRAM_NIB_W{~sel_n[1]}}; // [RL9]
         end
         sram_pkg::ORG_X9:
         begin
            m[0 +: `SRAM_LANE_W] = {`SRAM_LANE_W{~sel_n[0]}};
         end
         sram_pkg::ORG_X18:
         begin
            m[0 +: `SRAM_LANE_W]            = {`SRAM_LANE_W{~sel_n[0]}}; // [RL9]
            m[`SRAM_LANE_W +: `SRAM_LANE_W] = {`SRAM_LANE_W{~sel_n[1]}}; // [RL9]
         end
         sram_pkg::ORG_X36:
         begin
            // lane three follows the same nine-bit stride up to bit 35
            for (int i = 0; i < `SRAM_LANES; i++)
            begin
               m[i*`SRAM_LANE_W +: `SRAM_LANE_W] = {`SRAM_LANE_W{~sel_n[i]}}; // [RL11] [RL12]
            end
         end
      endcase
      return m;
   endfunction

   // masked merge: unselected lanes keep the stored bits
   function automatic logic [`SRAM_DW-1:0] merge(input logic [`SRAM_DW-1:0] old_w,
                                                 input logic [`SRAM_DW-1:0] new_w,
                                                 input logic [`SRAM_DW-1:0] mask);
      return (old_w & ~mask) | (new_w & mask); // [RL10]
   endfunction

   // two flops on every pin before any logic looks at it
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ck_s1_reg   <= '0;
         ck_s2_reg   <= '0;
         ck_prev_reg <= '0;
         ctl_s1_reg  <= '1;
         ctl_s2_reg  <= '1;
         addr_s1_reg <= '0;
         addr_s2_reg <= '0;
         data_s1_reg <= '0;
         data_s2_reg <= '0;
      end
      else
      begin
         ck_s1_reg   <= {i_c_n, i_c, i_k_n, i_k};
         ck_s2_reg   <= ck_s1_reg;
         ck_prev_reg <= ck_s2_reg;
         ctl_s1_reg  <= {i_lane_write_select_n, i_write_port_select_n, i_read_port_select_n};
         ctl_s2_reg  <= ctl_s1_reg;
         addr_s1_reg <= i_addr;
         addr_s2_reg <= addr_s1_reg;
         data_s1_reg <= i_wdata;
         data_s2_reg <= data_s1_reg;
      end
   end

   // edges are masked until the straps are read, so reset fill is no edge
   assign rise     = strap_done_reg ? (ck_s2_reg & ~ck_prev_reg) : '0;
   assign k_rise   = rise[`CK_K];
   assign kn_rise  = rise[`CK_KN];
   assign rd_sel_n = ctl_s2_reg[`CTL_RD];
   assign wr_sel_n = ctl_s2_reg[`CTL_WR];
   assign lane_n   = ctl_s2_reg[`CTL_LANE_LO +: `SRAM_LANES];

   // single clock strap is caught once after release and never changes
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         strap_cnt_reg  <= 2'h0;
         strap_done_reg <= 1'b0;
         single_reg     <= 1'b0;
      end
      else if (!strap_done_reg)
      begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         if (strap_cnt_reg == `STRAP_WAIT)
         begin
            strap_done_reg <= 1'b1;
            single_reg     <= ck_s2_reg[`CK_C] & ck_s2_reg[`CK_CN]; // [RL14]
         end
      end
   end

   // output timing edges: c pair, or the k pair in single clock mode
   assign first_edge  = single_reg ? kn_rise : rise[`CK_CN]; // [RL7] [RL14]
   assign second_edge = single_reg ? k_rise  : rise[`CK_C];  // [RL7] [RL14]

   // write port: first half on k, address and second half on kn
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr_state_reg <= sram_pkg::WR_IDLE; // [RL5]
         w0_data_reg  <= '0;
         w0_mask_reg  <= '0;
      end
      else if (k_rise && !wr_sel_n)
      begin
         wr_state_reg <= sram_pkg::WR_HALF;   // [RL1]
         w0_data_reg  <= data_s2_reg;         // [RL1] [RL7]
         w0_mask_reg  <= lane_mask(lane_n);   // [RL13]
      end
      else if (wr_commit)
      begin
         // a burst in flight finishes even if the select went high meanwhile
         wr_state_reg <= sram_pkg::WR_IDLE;   // [RL16]
      end
   end

   assign wr_commit = kn_rise && (wr_state_reg == sram_pkg::WR_HALF); // [RL1]
   assign w1_mask   = lane_mask(lane_n); // [RL13]
   assign even_new  = merge(mem_even[addr_s2_reg], w0_data_reg, w0_mask_reg);
   assign odd_new   = merge(mem_odd[addr_s2_reg], data_s2_reg, w1_mask);

   // both burst words land in one cycle, one per half array
   always_ff @(posedge i_mclk)
   begin
      if (wr_commit)
      begin
         mem_even[addr_s2_reg] <= even_new; // [RL6] [RL10]
         mem_odd[addr_s2_reg]  <= odd_new;  // [RL6] [RL10]
      end
   end

   // read port: latch address on k, fetch on the next k rise
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rd_pend_reg <= 1'b0; // [RL5]
         rd_addr_reg <= '0;
      end
      else if (k_rise)
      begin
         // nothing is started when the read select is high
         rd_pend_reg <= !rd_sel_n; // [RL2] [RL3]
         if (!rd_sel_n)
         begin
            rd_addr_reg <= addr_s2_reg; // [RL2]
         end
      end
   end

   assign fetch    = k_rise && rd_pend_reg;
   assign fwd_hit  = wr_commit && (addr_s2_reg == rd_addr_reg);
   assign fetch_w0 = fwd_hit ? even_new : mem_even[rd_addr_reg]; // [RL15]
   assign fetch_w1 = fwd_hit ? odd_new  : mem_odd[rd_addr_reg];  // [RL15]

   // fetched pair waits here while the buffer is full
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         src_cnt_reg <= 2'h0;
         src_w0_reg  <= '0;
         src_w1_reg  <= '0;
      end
      else if (fetch)
      begin
         // a stalled pair older than one cycle is overwritten: the pins cannot wait
         src_cnt_reg <= `BUF_DEPTH;
         src_w0_reg  <= fetch_w0; // [RL6]
         src_w1_reg  <= fetch_w1; // [RL6]
      end
      else if (buf_in_valid && buf_in_ready)
      begin
         src_cnt_reg <= src_cnt_reg - 2'h1;
      end
   end

   assign buf_in_valid = (src_cnt_reg != 2'h0);
   assign buf_in_data  = (src_cnt_reg == `BUF_DEPTH) ? {1'b0, src_w0_reg} : {1'b1, src_w1_reg};

   two_entry_buffer #(.WIDTH(`BUF_W)) u_rd_buf
   (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_in_valid  (buf_in_valid),
      .o_in_ready  (buf_in_ready),
      .i_in_data   (buf_in_data),
      .o_out_valid (buf_out_valid),
      .i_out_ready (buf_out_ready),
      .o_out_data  (buf_out_data)
   );

   // word 0 leaves on the first output edge, word 1 on the second
   assign buf_out_ready = buf_out_data[`BUF_SECOND] ? second_edge : first_edge; // [RL2]
   assign pop           = buf_out_valid && buf_out_ready;

   // output pins hold their level between edges, so a stopped clock freezes them
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rdata    <= '0;
         o_rdata_oe <= 1'b0; // [RL5]
      end
      else if (pop)
      begin
         o_rdata    <= buf_out_data[`SRAM_DW-1:0]; // [RL2] [RL7]
         o_rdata_oe <= 1'b1;                       // [RL2]
      end
      else if (first_edge || second_edge)
      begin
         o_rdata_oe <= 1'b0; // [RL17] [RL3] [RL4]
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_single_clock_mode <= 1'b0;
      end
      else
      begin
         o_single_clock_mode <= single_reg; // [RL14]
      end
   end

endmodule // burst_sram_core

// ### separate_port_burst_sram_cycles_tb.sv
// testbench: bursts through the controller model, checked against a local array
// assumes the 36-bit organisation; dual output clocks first, then a second
// reset with the c pair strapped high for single clock mode
`timescale 1ns/1ps
`include "sram_map.svh"

module separate_port_burst_sram_cycles_tb;
   logic                i_mclk;
   logic                i_rst;
   logic                k, k_n, c, c_n, rd_n, wr_n, oe, scm;
   logic [3:0]          lanes_n;
   logic [7:0]          addr;
   logic [35:0]         wdata, rdata, y1, hd;
   logic [35:0]         ev [256];
   logic [35:0]         od [256];
   logic                p_rd1 = 1'b0;
   logic                p_rd2 = 1'b0;
   logic [7:0]          p_a1 = 8'h00;
   int                  failures = 0;
   int                  cmp_count = 0;

   burst_sram_core #(.ORG(sram_pkg::ORG_X36)) dut_u
   (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_k(k), .i_k_n(k_n), .i_c(c), .i_c_n(c_n),
      .i_read_port_select_n(rd_n), .i_write_port_select_n(wr_n),
      .i_lane_write_select_n(lanes_n), .i_addr(addr), .i_wdata(wdata),
      .o_rdata(rdata), .o_rdata_oe(oe), .o_single_clock_mode(scm)
   );
   sram_ctrl_model m_u
   (
      .i_mclk(i_mclk), .o_k(k), .o_k_n(k_n), .o_c(c), .o_c_n(c_n),
      .o_read_port_select_n(rd_n), .o_write_port_select_n(wr_n),
      .o_lane_write_select_n(lanes_n), .o_addr(addr), .o_wdata(wdata),
      .i_rdata(rdata), .i_rdata_oe(oe)
   );

   initial
   begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end

   task final_report;
      $display("failures=%0d comparisons=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task ck(input logic ok, input string msg);
      cmp_count++;
      if (!ok)
      begin
         failures++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   function automatic logic [35:0] mrg(input logic [35:0] o, n, input logic [3:0] m);
      for (int i = 0; i < 4; i++)
         mrg[9*i +: 9] = m[i] ? o[9*i +: 9] : n[9*i +: 9];
   endfunction

   // one pin cycle plus the read pipeline checks that fall due in it
   task go(input logic rn, wn, input logic [7:0] ra, wa, input logic [35:0] w0, w1,
           input logic [3:0] m0, m1);
      logic [35:0] x0, x1;
      x0 = ev[p_a1];
      x1 = od[p_a1];
      m_u.cyc(rn, wn, ra, wa, w0, w1, m0, m1);
      if (!wn)
      begin
         ev[wa] = mrg(ev[wa], w0, m0);
         od[wa] = mrg(od[wa], w1, m1);
      end
      if (p_rd2)
         ck(m_u.oe_c === 1'b1 && m_u.cap_c === y1, "second word");
      else if (!p_rd1)
         ck(m_u.oe_c === 1'b0, "output not idle");
      ck(m_u.oe_cn === p_rd1, "output enable");
      if (p_rd1)
         ck(m_u.cap_cn === x0, "first word");
      p_rd2 = p_rd1;
      y1 = x1;
      p_rd1 = !rn;
      p_a1 = ra;
   endtask

   // write data and lanes here are junk that must be ignored
   task nop(input int n);
      repeat (n) go(1'b1, 1'b1, 8'hA5, 8'h5A, 36'hF0F0F0F0F, 36'h0F0F0F0F0, 4'h0, 4'h0);
   endtask

   task t_reset;
      ck(oe === 1'b0 && rdata === 36'h0 && scm === 1'b0, "reset state");
   endtask

   task t_wr_rd;
      go(1'b1, 1'b0, 8'h00, 8'h05, 36'h123456789, 36'hABCDEF012, 4'h0, 4'h0);
      go(1'b0, 1'b1, 8'h05, 8'h00, 36'h0, 36'h0, 4'hF, 4'hF);
      nop(3);
   endtask

   task t_lanes;
      for (int i = 0; i < 4; i++)
         go(1'b1, 1'b0, 8'h00, 8'(8'h10 + i), 36'h0, 36'h0, 4'h0, 4'h0);
      for (int i = 0; i < 4; i++)
         go(1'b1, 1'b0, 8'h00, 8'(8'h10 + i), 36'hFFFFFFFFF, 36'h1FF3FE7FC,
            ~(4'h1 << i), (i == 3) ? 4'hF : ~(4'h2 << i));
      for (int i = 0; i < 4; i++)
         go(1'b0, 1'b1, 8'(8'h10 + i), 8'h00, 36'h0, 36'h0, 4'hF, 4'hF);
      nop(3);
   endtask

   task t_concur;
      go(1'b1, 1'b0, 8'h00, 8'h20, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
      go(1'b0, 1'b0, 8'h20, 8'h20, 36'h333333333, 36'h444444444, 4'h0, 4'h0);
      go(1'b0, 1'b0, 8'h20, 8'h20, 36'h555555555, 36'h666666666, 4'h5, 4'hA);
      nop(3);
   endtask

   task t_stop;
      logic h_oe;
      go(1'b0, 1'b1, 8'h11, 8'h00, 36'h0, 36'h0, 4'hF, 4'hF);
      nop(1);
      hd = rdata;
      h_oe = oe;
      m_u.park(40);
      ck(rdata === hd && oe === h_oe && oe === 1'b1, "stopped clock hold");
      nop(3);
   endtask

   // c pair held high through reset; outputs must then follow the k pair alone
   task t_single;
      i_rst = 1'b1;
      m_u.strap(1'b1);
      repeat (8) @(negedge i_mclk);
      i_rst = 1'b0;
      repeat (8) @(negedge i_mclk);
      ck(scm === 1'b1 && oe === 1'b0, "single clock strap");
      go(1'b1, 1'b0, 8'h00, 8'h30, 36'h13579BDF0, 36'h2468ACE01, 4'h0, 4'h0);
      go(1'b0, 1'b1, 8'h30, 8'h00, 36'h0, 36'h0, 4'hF, 4'hF);
      nop(3);
   endtask

   initial
   begin
      i_rst = 1'b1;
      repeat (8) @(negedge i_mclk);
      i_rst = 1'b0;
      t_reset;
      t_wr_rd;
      t_lanes;
      t_concur;
      t_stop;
      t_single;
      final_report;
   end

   // the tests need about 1,000 mclk; far beyond that means a hang
   initial
   begin
      repeat (20000) @(posedge i_mclk);
      failures++;
      final_report;
   end
endmodule // separate_port_burst_sram_cycles_tb

// ### sram_ctrl_model.sv
// controller model: drives clock pins, selects, address and write data
// assumes a free-running i_mclk; pins change on its falling edge only
`timescale 1ns/1ps
`include "sram_map.svh"

module sram_ctrl_model
(
   // clock
   input  wire logic                i_mclk,
   // pins toward the sram
   output logic                     o_k,
   output logic                     o_k_n,
   output logic                     o_c,
   output logic                     o_c_n,
   output logic                     o_read_port_select_n,
   output logic                     o_write_port_select_n,
   output logic [`SRAM_LANES-1:0]   o_lane_write_select_n,
   output logic [`SRAM_AW-1:0]      o_addr,
   output logic [`SRAM_DW-1:0]      o_wdata,
   // read data from the sram
   input  wire logic [`SRAM_DW-1:0] i_rdata,
   input  wire logic                i_rdata_oe
);
   logic [`SRAM_DW-1:0] cap_c;
   logic [`SRAM_DW-1:0] cap_cn;
   logic                oe_c;
   logic                oe_cn;
   logic                single_mode;

   initial
   begin
      {o_k, o_k_n} = 2'h0;
      {o_c, o_c_n} = 2'h0;
      single_mode = 1'b0;
      {o_read_port_select_n, o_write_port_select_n} = 2'h3;
      o_lane_write_select_n = 4'hF;
      o_addr = 8'h00;
      o_wdata = 36'h0;
   end

   task wt(input int n);
      repeat (n) @(negedge i_mclk);
   endtask

   // strap level for the c pair; only meaningful while reset is held
   task strap(input logic v);
      single_mode = v;
      {o_c, o_c_n} = {v, v};
   endtask

   // one pin cycle; c pair tracks k pair with zero skew, or stays high in single mode
   task cyc(input logic rn, wn, input logic [`SRAM_AW-1:0] ra, wa,
            input logic [`SRAM_DW-1:0] w0, w1, input logic [3:0] m0, m1);
      wt(4);
      {o_read_port_select_n, o_write_port_select_n} = {rn, wn};
      {o_addr, o_wdata, o_lane_write_select_n} = {ra, w0, m0};
      wt(4);
      {o_k, o_k_n} = 2'h2;
      if (!single_mode)
         {o_c, o_c_n} = 2'h2;
      wt(4);
      {o_addr, o_wdata, o_lane_write_select_n} = {wa, w1, m1};
      wt(3);
      {cap_c, oe_c} = {i_rdata, i_rdata_oe};
      wt(1);
      {o_k, o_k_n} = 2'h1;
      if (!single_mode)
         {o_c, o_c_n} = 2'h1;
      wt(7);
      {cap_cn, oe_cn} = {i_rdata, i_rdata_oe};
   endtask

   // parking k equal to k_n; selects and data wander while stopped
   task park(input int n);
      o_k_n = 1'b0;
      {o_read_port_select_n, o_write_port_select_n} = 2'h0;
      o_wdata = ~o_wdata;
      wt(n);
   endtask
endmodule // sram_ctrl_model

// ### sram_cycles_chk_sva.sv
// checker: pin-level read timing and hold behaviour of the burst sram core
// assumes pin clocks change on falling mclk edges, at least 4 mclk apart
`timescale 1ns/1ps
`include "sram_map.svh"

module sram_cycles_chk
(
   // clock and reset
   input wire logic                i_mclk,
   input wire logic                i_rst,
   // pins watched
   input wire logic                i_k,
   input wire logic                i_k_n,
   input wire logic                i_c,
   input wire logic                i_c_n,
   input wire logic                i_read_port_select_n,
   input wire logic [`SRAM_DW-1:0] o_rdata,
   input wire logic                o_rdata_oe,
   input wire logic                o_single_clock_mode
);
   logic [3:0] pins_q;
   logic [3:0] c_age;
   logic [3:0] cn_age;
   logic [3:0] pin_age;
   logic [3:0] rst_age;
   logic [2:0] rd_hist;

   // ages saturate at 15 so a stopped clock never wraps back into a window
   always_ff @(posedge i_mclk or posedge i_rst)
      if (i_rst)
      begin
         pins_q  <= 4'h0;
         c_age   <= 4'hF;
         cn_age  <= 4'hF;
         pin_age <= 4'hF;
         rst_age <= 4'h0;
         rd_hist <= 3'h0;
      end
      else
      begin
         pins_q  <= {i_k, i_k_n, i_c, i_c_n};
         // single clock mode times the outputs from the k pair, not the c pair
         c_age   <= (o_single_clock_mode ? (i_k && !pins_q[3]) : (i_c && !pins_q[1]))
                    ? 4'h0 : c_age + (c_age != 4'hF);
         cn_age  <= (o_single_clock_mode ? (i_k_n && !pins_q[2]) : (i_c_n && !pins_q[0]))
                    ? 4'h0 : cn_age + (cn_age != 4'hF);
         pin_age <= ({i_k, i_k_n, i_c, i_c_n} != pins_q) ? 4'h0 : pin_age + (pin_age != 4'hF);
         rst_age <= rst_age + (rst_age != 4'hF);
         if (i_k && !pins_q[3])
            rd_hist <= {rd_hist[1:0], !i_read_port_select_n};
      end

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   sequence s_read_req;
      i_k && !pins_q[3] && !i_read_port_select_n;
   endsequence
   // bound suits pin cycles of about 23 mclk
   sequence s_word0;
      ##[1:60] (cn_age == 4'h6 && o_rdata_oe);
   endsequence

   property p_reset_idle;
      $fell(i_rst) |-> !o_rdata_oe && o_rdata == 36'h0;
   endproperty
   property p_read_answer;
      s_read_req |-> s_word0;
   endproperty
   property p_oe_at_cn;
      cn_age == 4'h6 |-> o_rdata_oe == rd_hist[1];
   endproperty
   property p_word1_at_c;
      c_age == 4'h6 && rd_hist[2] |-> o_rdata_oe;
   endproperty
   property p_oe_rise;
      $rose(o_rdata_oe) |-> cn_age inside {[2:7]};
   endproperty
   property p_data_edge;
      $changed(o_rdata) |-> (c_age inside {[2:7]}) || (cn_age inside {[2:7]});
   endproperty
   property p_stop_hold;
      pin_age > 4'h8 |-> $stable(o_rdata) && $stable(o_rdata_oe);
   endproperty
   property p_idle_hold;
      !o_rdata_oe && !$past(o_rdata_oe) |-> $stable(o_rdata);
   endproperty
   property p_strap_fixed;
      $changed(o_single_clock_mode) |-> rst_age < 4'h8;
   endproperty

   a_reset_idle: assert property (p_reset_idle) else $error("outputs active after reset");
   a_read_answer: assert property (p_read_answer) else $error("read got no first word");
   a_oe_at_cn: assert property (p_oe_at_cn) else $error("enable wrong at cn");
   a_word1_at_c: assert property (p_word1_at_c) else $error("second word missing");
   a_oe_rise: assert property (p_oe_rise) else $error("enable rose off cn");
   a_data_edge: assert property (p_data_edge) else $error("data moved off clock");
   a_stop_hold: assert property (p_stop_hold) else $error("output moved while stopped");
   a_idle_hold: assert property (p_idle_hold) else $error("idle data moved");
   a_strap_fixed: assert property (p_strap_fixed) else $error("strap changed");
endmodule // sram_cycles_chk

bind burst_sram_core sram_cycles_chk chk_u
(
   .i_mclk               (i_mclk),
   .i_rst                (i_rst),
   .i_k                  (i_k),
   .i_k_n                (i_k_n),
   .i_c                  (i_c),
   .i_c_n                (i_c_n),
   .i_read_port_select_n (i_read_port_select_n),
   .o_rdata              (o_rdata),
   .o_rdata_oe           (o_rdata_oe),
   .o_single_clock_mode  (o_single_clock_mode)
);

// ### sram_map.svh
// constants of the two-port burst sram model: widths, lanes, pin slots
// assumes every includer is compiled after this header only once
`ifndef SRAM_MAP_SVH
`define SRAM_MAP_SVH

// burst address width and word geometry
`define SRAM_AW        8
`define SRAM_DW        36
`define SRAM_LANES     4
`define SRAM_LANE_W    9
`define SRAM_NIB_W     4

// slots of the synchronised clock-pin vector
`define CK_W           4
`define CK_K           0
`define CK_KN          1
`define CK_C           2
`define CK_CN          3

// slots of the synchronised control vector
`define CTL_W          6
`define CTL_RD         0
`define CTL_WR         1
`define CTL_LANE_LO    2

// buffer geometry: data plus a second-word flag
`define BUF_W          37
`define BUF_DEPTH      2'h2
`define BUF_SECOND     36

// cycles after reset release before the clock straps are trusted
`define STRAP_WAIT     2'h3

`endif

// ### sram_pkg.sv
// types shared by the burst sram model
// assumes sram_map.svh is compiled alongside
package sram_pkg;

   typedef enum logic
   {
      WR_IDLE = 1'b0,
      WR_HALF = 1'b1
   } wr_state_t;

   typedef enum logic [1:0]
   {
      ORG_X8  = 2'h0,
      ORG_X9  = 2'h1,
      ORG_X18 = 2'h2,
      ORG_X36 = 2'h3
   } org_t;

endpackage

// ### two_entry_buffer.sv
// two-entry valid/ready buffer between read fetch and output launch
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
`include "sram_map.svh"

module two_entry_buffer
#(
   parameter int WIDTH = `BUF_W
)
(
   // clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   // filling side
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   // draining side
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);

   logic [WIDTH-1:0] ent_reg [2];
   logic             wp_reg;
   logic             rp_reg;
   logic [1:0]       cnt_reg;
   logic             push;
   logic             pop;

   assign o_in_ready  = (cnt_reg != `BUF_DEPTH);
   assign o_out_valid = (cnt_reg != 2'h0);
   assign o_out_data  = ent_reg[rp_reg];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_ff @(posedge i_mclk)
   begin
      if (push)
      begin
         ent_reg[wp_reg] <= i_in_data;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wp_reg  <= 1'b0;
         rp_reg  <= 1'b0;
         cnt_reg <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wp_reg <= ~wp_reg;
         end
         if (pop)
         begin
            rp_reg <= ~rp_reg;
         end
         if (push && !pop)
         begin
            cnt_reg <= cnt_reg + 2'h1;
         end
         else if (pop && !push)
         begin
            cnt_reg <= cnt_reg - 2'h1;
         end
      end
   end

endmodule // two_entry_buffer
